// >>> apc_map.vh
// Register offsets, field positions, reset values and timing for audio control
`ifndef APC_MAP_VH
`define APC_MAP_VH

// Register offsets on the control port
`define APC_REG_DCTL       8'h02
`define APC_REG_VCFG       8'h03
`define APC_REG_LVOL       8'h04
`define APC_REG_RVOL       8'h05
`define APC_REG_ACTL       8'h06

// Reset values
`define APC_DCTL_RST       8'h14
`define APC_VCFG_RST       8'h80
`define APC_VOL_RST        8'hcf
`define APC_ACTL_RST       8'h51

// Writable bit masks, reserved bits stay zero
`define APC_DCTL_WMASK     8'hbf
`define APC_VCFG_WMASK     8'h83

// Field positions
`define APC_SKIP_BIT       7
`define APC_BOOST_HI       5
`define APC_BOOST_LO       4
`define APC_SPEED_BIT      3
`define APC_FMT_HI         2
`define APC_FMT_LO         0
`define APC_FADE_BIT       7
`define APC_MUTE_R_BIT     1
`define APC_MUTE_L_BIT     0
`define APC_SIDE_BIT       1

// Input format codes
`define APC_FMT_RJ24       3'h0
`define APC_FMT_RJ20       3'h1
`define APC_FMT_RJ18       3'h2
`define APC_FMT_RJ16       3'h3
`define APC_FMT_I2S        3'h4
`define APC_FMT_LJ         3'h5

// Right-justified word lengths
`define APC_BITS_24        5'h18
`define APC_BITS_20        5'h14
`define APC_BITS_18        5'h12
`define APC_BITS_16        5'h10

// Volume code landmarks
`define APC_VOL_FLOOR      8'h07
`define APC_VOL_ZERO       8'hcf
`define APC_VOL_MUTE       8'h00

// Timing
`define APC_CLK_PERIOD_NS  100
`define APC_FADE_STEP_NS   2000
`define APC_FADE_STEP_CYC  ((`APC_FADE_STEP_NS + `APC_CLK_PERIOD_NS - 1) \
                            / `APC_CLK_PERIOD_NS)

`endif

// >>> apc_sync3.v
// Three-flop pin synchroniser with agreement filter
`timescale 1ns/1ns
module apc_sync3 #(
    parameter RST_VAL = 1'b1    // Idle level of the pin
) (
    input  wire ref_clk,
    input  wire rst_n,
    input  wire pin,
    output reg  level,
    output wire next_level
);
    reg ff1;                    // First stage, read only by ff2
    reg ff2;                    // Second stage
    reg ff3;                    // Third stage

    // New level once second and third stage agree
    assign next_level = (ff2 == ff3) ? ff3 : level;

    // Shift chain and filtered level
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ff1   <= RST_VAL;
            ff2   <= RST_VAL;
            ff3   <= RST_VAL;
            level <= RST_VAL;
        end else begin
            ff1   <= pin;
            ff2   <= ff1;
            ff3   <= ff2;
            level <= next_level;
        end
    end
endmodule // apc_sync3

// >>> apc_audio_path_regs.v
// Audio path control registers behind a two-wire control port
`timescale 1ns/1ns
`include "apc_map.vh"

// Summary of operation
// - Skip bit routes audio around lowcut filter
// - Boost field adds 0, 6, 12, 18 dB
// - Speed bit picks single or double rates
// - Format codes 0-3 select right-justified widths
// - Code 4 is I2S, 5 left-justified
// - Fade bit enables fading, set after reset
// - Right mute bit gives 50/50 output when side bit picks right input
// - Left mute bit gives 50/50 output when side bit picks left input
// - Left code steps half dB, CF is 0 dB
// - Code 07 is -100 dB, below mutes
// - Right volume uses same code scale
// - Side bit picks left or right input
module apc_audio_path_regs #(
    parameter [6:0] DEV_ADDR = 7'h2a    // Bus address, value arbitrary
) (
    input  wire       ref_clk,
    input  wire       rst_n,
    input  wire       scl_pin,
    input  wire       sda_in,
    output reg        sda_out,
    output reg        sda_oe,
    output reg        lowcut_filter_skip,
    output reg  [1:0] boost_shift,
    output reg        rate_speed_select,
    output reg        fmt_right_just,
    output reg        fmt_i2s,
    output reg        fmt_left_just,
    output reg  [4:0] rj_word_bits,
    output reg        fade_enable,
    output reg        input_side_select,
    output reg  [7:0] left_gain_code,
    output reg  [7:0] right_gain_code,
    output reg  [8:0] left_gain_half_db,
    output reg  [8:0] right_gain_half_db,
    output reg  [8:0] amp_gain_half_db,
    output reg        amp_mute_5050
);
    // One-hot control port states
    localparam [4:0] ST_IDLE = 5'h01;   // Waiting for start
    localparam [4:0] ST_RX   = 5'h02;   // Receiving a byte
    localparam [4:0] ST_ACK  = 5'h04;   // Driving acknowledge
    localparam [4:0] ST_TX   = 5'h08;   // Sending a byte
    localparam [4:0] ST_RACK = 5'h10;   // Sampling master acknowledge
    localparam       FADE_CYC = `APC_FADE_STEP_CYC;    // Cycles per step
    reg  [7:0]  dctl;           // Digital path control
    reg  [7:0]  vcfg;           // Volume configuration
    reg  [7:0]  lvol;           // Left volume target code
    reg  [7:0]  rvol;           // Right volume target code
    reg  [7:0]  actl;           // Analog control, side select
    reg  [4:0]  state;          // Port state
    reg  [3:0]  bit_cnt;        // Bits of current byte
    reg  [1:0]  byte_idx;       // 0 address, 1 pointer, 2 data
    reg  [7:0]  shreg;          // Receive shift register
    reg  [7:0]  tx_sh;          // Transmit shift register
    reg  [7:0]  pointer;        // Register pointer
    reg         rw;             // Read transfer
    reg         nack;           // Master refused next byte
    reg  [15:0] fade_cnt;       // Fade step timer
    reg  [7:0]  app_l;          // Applied left code
    reg  [7:0]  app_r;          // Applied right code
    reg  [7:0]  next_app_l;     // Next applied left code
    reg  [7:0]  next_app_r;     // Next applied right code
    wire        scl_l;          // Filtered clock level
    wire        scl_n;          // Filtered clock, next value
    wire        sda_l;          // Filtered data level
    wire        sda_n;          // Filtered data, next value
    wire        scl_rise;       // Clock rising
    wire        scl_fall;       // Clock falling
    wire        start_det;      // Start condition
    wire        stop_det;       // Stop condition
    wire        byte_done;      // Eighth bit done at clock fall
    wire        wr_en;          // Data byte write strobe
    wire        fade_tick;      // One fade step due
    wire [7:0]  tgt_l;          // Left target after mute
    wire [7:0]  tgt_r;          // Right target after mute

    // Clock and data line synchronisers, both idle high
    apc_sync3 #(.RST_VAL(1'b1)) u_scl (.ref_clk(ref_clk), .rst_n(rst_n),
        .pin(scl_pin), .level(scl_l), .next_level(scl_n));
    apc_sync3 #(.RST_VAL(1'b1)) u_sda (.ref_clk(ref_clk), .rst_n(rst_n),
        .pin(sda_in), .level(sda_l), .next_level(sda_n));

    // Edge and condition detection on filtered lines
    assign scl_rise  = scl_n & ~scl_l;
    assign scl_fall  = ~scl_n & scl_l;
    assign start_det = scl_n & scl_l & sda_l & ~sda_n;
    assign stop_det  = scl_n & scl_l & ~sda_l & sda_n;
    assign byte_done = (state == ST_RX) && scl_fall && (bit_cnt == 4'h8);
    assign wr_en     = byte_done && (byte_idx == 2'h2);

    // Read data by pointer, unmapped reads as zero
    function [7:0] rd_mux;
        input [7:0] addr;
        begin
            case (addr)
                `APC_REG_DCTL: rd_mux = dctl;
                `APC_REG_VCFG: rd_mux = vcfg;
                `APC_REG_LVOL: rd_mux = lvol;
                `APC_REG_RVOL: rd_mux = rvol;
                `APC_REG_ACTL: rd_mux = actl;
                default:       rd_mux = 8'h00;
            endcase
        end
    endfunction

    // Control port byte engine
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state    <= ST_IDLE;
            bit_cnt  <= 4'h0;
            byte_idx <= 2'h0;
            shreg    <= 8'h00;
            tx_sh    <= 8'h00;
            pointer  <= 8'h00;
            rw       <= 1'b0;
            nack     <= 1'b0;
            sda_oe   <= 1'b0;
            sda_out  <= 1'b0;
        end else if (start_det) begin
            // Start or repeated start opens an address byte
            state    <= ST_RX;
            bit_cnt  <= 4'h0;
            byte_idx <= 2'h0;
            sda_oe   <= 1'b0;
        end else if (stop_det) begin
            state  <= ST_IDLE;
            sda_oe <= 1'b0;
        end else begin
            case (state)
                ST_RX: begin
                    if (scl_rise) begin
                        shreg   <= {shreg[6:0], sda_n};
                        bit_cnt <= bit_cnt + 4'h1;
                    end else if (byte_done) begin
                        bit_cnt <= 4'h0;
                        if (byte_idx == 2'h0) begin
                            // Address byte, answer only our own
                            if (shreg[7:1] == DEV_ADDR) begin
                                rw     <= shreg[0];
                                sda_oe <= 1'b1;
                                state  <= ST_ACK;
                            end else begin
                                state <= ST_IDLE;
                            end
                        end else begin
                            // Pointer or data byte, always acknowledged
                            pointer <= (byte_idx == 2'h1) ? shreg
                                                          : pointer + 8'h01;
                            sda_oe <= 1'b1;
                            state  <= ST_ACK;
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        byte_idx <= (byte_idx == 2'h2) ? 2'h2
                                                       : byte_idx + 2'h1;
                        bit_cnt  <= 4'h0;
                        if (rw) begin
                            // Read: first bit goes out at once
                            tx_sh  <= rd_mux(pointer);
                            sda_oe <= ~|(rd_mux(pointer) & 8'h80);
                            state  <= ST_TX;
                        end else begin
                            sda_oe <= 1'b0;
                            state  <= ST_RX;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        if (bit_cnt == 4'h7) begin
                            sda_oe  <= 1'b0;
                            bit_cnt <= 4'h0;
                            state   <= ST_RACK;
                        end else begin
                            tx_sh   <= {tx_sh[6:0], 1'b0};
                            sda_oe  <= ~tx_sh[6];
                            bit_cnt <= bit_cnt + 4'h1;
                        end
                    end
                end
                ST_RACK: begin
                    if (scl_rise) begin
                        nack <= sda_n;
                    end else if (scl_fall) begin
                        pointer <= pointer + 8'h01;
                        if (nack) begin
                            state <= ST_IDLE;
                        end else begin
                            tx_sh  <= rd_mux(pointer + 8'h01);
                            sda_oe <= ~|(rd_mux(pointer + 8'h01) & 8'h80);
                            state  <= ST_TX;
                        end
                    end
                end
                ST_IDLE: sda_oe <= 1'b0;    // Bus released while idle
                default: begin
                    state  <= ST_IDLE;
                    sda_oe <= 1'b0;
                end
            endcase
        end
    end

    // Register file writes, reserved bits forced to zero
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            dctl <= `APC_DCTL_RST;
            vcfg <= `APC_VCFG_RST;  // Fade on after reset
            lvol <= `APC_VOL_RST;   // 0 dB after reset
            rvol <= `APC_VOL_RST;   // Same default on right
            actl <= `APC_ACTL_RST;
        end else if (wr_en) begin
            case (pointer)
                `APC_REG_DCTL: dctl <= shreg & `APC_DCTL_WMASK;
                `APC_REG_VCFG: vcfg <= shreg & `APC_VCFG_WMASK;
                `APC_REG_LVOL: lvol <= shreg;
                `APC_REG_RVOL: rvol <= shreg;
                `APC_REG_ACTL: actl <= shreg;
                default: ;                  // Unmapped writes are dropped
            endcase
        end
    end

    // Mute bits pull the target down to full mute
    assign tgt_l = vcfg[`APC_MUTE_L_BIT] ? `APC_VOL_MUTE : lvol;
    assign tgt_r = vcfg[`APC_MUTE_R_BIT] ? `APC_VOL_MUTE : rvol;
    assign fade_tick = (fade_cnt == FADE_CYC[15:0] - 16'h0001);

    // Next applied code: one step per tick or jump when fade is off
    always @* begin
        next_app_l = app_l;
        next_app_r = app_r;
        if (!vcfg[`APC_FADE_BIT]) begin
            next_app_l = tgt_l;
            next_app_r = tgt_r;
        end else if (fade_tick) begin
            if (app_l < tgt_l) begin
                next_app_l = app_l + 8'h01;
            end else if (app_l > tgt_l) begin
                next_app_l = app_l - 8'h01;
            end
            next_app_r = (app_r < tgt_r) ? app_r + 8'h01
                       : (app_r > tgt_r) ? app_r - 8'h01 : app_r;
        end
    end

    // Fade timer and applied gain codes
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            fade_cnt <= 16'h0000;
            app_l    <= `APC_VOL_RST;
            app_r    <= `APC_VOL_RST;
        end else begin
            fade_cnt <= fade_tick ? 16'h0000 : fade_cnt + 16'h0001;
            app_l    <= next_app_l;
            app_r    <= next_app_r;
        end
    end

    // Decoded control outputs, all registered
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            lowcut_filter_skip <= 1'b0;
            boost_shift        <= 2'h1;
            rate_speed_select  <= 1'b0;
            fmt_right_just     <= 1'b0;
            fmt_i2s            <= 1'b1;
            fmt_left_just      <= 1'b0;
            rj_word_bits       <= 5'h00;
            fade_enable        <= 1'b1;
            input_side_select  <= 1'b0;
        end else begin
            lowcut_filter_skip <= dctl[`APC_SKIP_BIT];
            boost_shift <= dctl[`APC_BOOST_HI:`APC_BOOST_LO];
            rate_speed_select  <= dctl[`APC_SPEED_BIT];
            fmt_right_just <= (dctl[`APC_FMT_HI:`APC_FMT_LO]
                               < `APC_FMT_I2S);
            fmt_i2s <= (dctl[`APC_FMT_HI:`APC_FMT_LO]
                        == `APC_FMT_I2S);
            fmt_left_just <= (dctl[`APC_FMT_HI:`APC_FMT_LO]
                              == `APC_FMT_LJ);
            case (dctl[`APC_FMT_HI:`APC_FMT_LO])
                `APC_FMT_RJ24: rj_word_bits <= `APC_BITS_24;
                `APC_FMT_RJ20: rj_word_bits <= `APC_BITS_20;
                `APC_FMT_RJ18: rj_word_bits <= `APC_BITS_18;
                `APC_FMT_RJ16: rj_word_bits <= `APC_BITS_16;
                default:       rj_word_bits <= 5'h00;
            endcase
            fade_enable       <= vcfg[`APC_FADE_BIT];
            input_side_select <= actl[`APC_SIDE_BIT];
        end
    end

    // Gain in half dB relative to the 0 dB code, selected channel
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            left_gain_code     <= `APC_VOL_RST;
            right_gain_code    <= `APC_VOL_RST;
            left_gain_half_db  <= 9'h000;
            right_gain_half_db <= 9'h000;
            amp_gain_half_db   <= 9'h000;
            amp_mute_5050      <= 1'b0;
        end else begin
            left_gain_code  <= app_l;
            right_gain_code <= app_r;
            left_gain_half_db <= {1'b0, app_l}
                               - {1'b0, `APC_VOL_ZERO};
            right_gain_half_db <= {1'b0, app_r}
                                - {1'b0, `APC_VOL_ZERO};
            if (actl[`APC_SIDE_BIT]) begin
                // Left input feeds the amplifier
                amp_gain_half_db <= {1'b0, app_l}
                                  - {1'b0, `APC_VOL_ZERO};
                amp_mute_5050 <= (app_l < `APC_VOL_FLOOR);
            end else begin
                // Right input feeds the amplifier
                amp_gain_half_db <= {1'b0, app_r}
                                  - {1'b0, `APC_VOL_ZERO};
                amp_mute_5050 <= (app_r < `APC_VOL_FLOOR);
            end
        end
    end
endmodule // apc_audio_path_regs

// >>> apc_path_monitor.sv
// Checker on the audio path control register outputs
`timescale 1ns/1ns
module apc_path_monitor (
    input wire       ref_clk,
    input wire       rst_n,
    input wire       fmt_right_just,
    input wire       fmt_i2s,
    input wire       fmt_left_just,
    input wire [4:0] rj_word_bits,
    input wire       fade_enable,
    input wire       input_side_select,
    input wire [7:0] left_gain_code,
    input wire [7:0] right_gain_code,
    input wire [8:0] left_gain_half_db,
    input wire [8:0] right_gain_half_db,
    input wire [8:0] amp_gain_half_db,
    input wire       amp_mute_5050
);
    // Applied code of the channel feeding the amplifier
    wire [7:0] sel = input_side_select ? left_gain_code : right_gain_code;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    property p_fmt;
        $onehot0({fmt_right_just, fmt_i2s, fmt_left_just});
    endproperty
    a_fmt: assert property (p_fmt) else $error("fmt flags");
    property p_rj;
        fmt_right_just ? rj_word_bits inside {5'h18, 5'h14, 5'h12, 5'h10}
                       : rj_word_bits == 5'h00;
    endproperty
    a_rj: assert property (p_rj) else $error("rj length");
    property p_ldb;
        $stable(left_gain_code)[*3] |->
            left_gain_half_db == {1'b0, left_gain_code} - 9'h0cf;
    endproperty
    a_ldb: assert property (p_ldb) else $error("left db");
    property p_amp;
        $stable({input_side_select, left_gain_half_db,
                 right_gain_half_db})[*3] |-> amp_gain_half_db ==
            (input_side_select ? left_gain_half_db : right_gain_half_db);
    endproperty
    a_amp: assert property (p_amp) else $error("amp pick");
    property p_mute;
        $stable(sel)[*3] |-> amp_mute_5050 == (sel < 8'h07);
    endproperty
    a_mute: assert property (p_mute) else $error("mute");
    property p_step;
        fade_enable && $past(fade_enable) && $changed(left_gain_code) |->
            8'(left_gain_code - $past(left_gain_code)) inside {8'h01, 8'hff};
    endproperty
    a_step: assert property (p_step) else $error("fade step");
    property p_hold;
        fade_enable && $changed(left_gain_code) |=>
            $stable(left_gain_code)[*8];
    endproperty
    a_hold: assert property (p_hold) else $error("fade rate");
    property p_rst;
        $rose(rst_n) |-> fade_enable && fmt_i2s && left_gain_code == 8'hcf;
    endproperty
    a_rst: assert property (p_rst) else $error("reset state");
endmodule // apc_path_monitor

bind apc_audio_path_regs apc_path_monitor apc_path_monitor_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .fmt_right_just(fmt_right_just),
    .fmt_i2s(fmt_i2s), .fmt_left_just(fmt_left_just),
    .rj_word_bits(rj_word_bits), .fade_enable(fade_enable),
    .input_side_select(input_side_select), .left_gain_code(left_gain_code),
    .right_gain_code(right_gain_code), .amp_mute_5050(amp_mute_5050),
    .left_gain_half_db(left_gain_half_db),
    .right_gain_half_db(right_gain_half_db),
    .amp_gain_half_db(amp_gain_half_db)
);

// >>> apc_ctl_master.sv
// Control port master model: drives the link clock, pulls data low
`timescale 1ns/1ns
module apc_ctl_master (
    input  wire ref_clk,
    input  wire sda,
    output reg  scl,
    output reg  sda_low
);
    // Idle: clock parked high, data released to the pull-up
    initial begin
        scl     = 1'b1;
        sda_low = 1'b0;
    end
    // Wait n reference edges; half a link period is four
    task automatic tick(input integer n);
        repeat (n) @(posedge ref_clk);
    endtask
    // One link clock: data moves mid-low, sampled at end of high
    task automatic pulse(input reg b, output reg r);
        scl <= 1'b0;
        tick(2);
        sda_low <= !b;
        tick(2);
        scl <= 1'b1;
        tick(4);
        r = sda;
    endtask
    // Data edge under a high clock: low for start, high for stop
    task automatic frame(input reg low);
        scl <= 1'b0;
        tick(4);
        sda_low <= !low;
        tick(4);
        scl <= 1'b1;
        tick(4);
        sda_low <= low;
        tick(4);
    endtask
    // Byte out, top bit first, then the acknowledge clock
    task automatic put(input [7:0] v, output reg ack);
        reg r;
        integer k;
        for (k = 7; k >= 0; k = k - 1)
            pulse(v[k], r);
        pulse(1'b1, r);
        ack = !r;
    endtask
    // Register write; ok when every byte was acknowledged
    task automatic reg_write(input [6:0] dev, input [7:0] ptr,
                             input [7:0] v, output reg ok);
        reg a0, a1, a2;
        frame(1'b1);
        put({dev, 1'b0}, a0);
        put(ptr, a1);
        put(v, a2);
        frame(1'b0);
        ok = a0 & a1 & a2;
    endtask
    // Register read: pointer, restart, one byte, then no acknowledge
    task automatic reg_read(input [6:0] dev, input [7:0] ptr,
                            output reg [7:0] v, output reg ok);
        reg a0, a1, a2, r;
        integer k;
        frame(1'b1);
        put({dev, 1'b0}, a0);
        put(ptr, a1);
        frame(1'b1);
        put({dev, 1'b1}, a2);
        for (k = 7; k >= 0; k = k - 1)
            pulse(1'b1, v[k]);
        pulse(1'b1, r);
        frame(1'b0);
        ok = a0 & a1 & a2;
    endtask
endmodule // apc_ctl_master

// >>> tb.sv
// Self-checking bench for the audio path control registers
`timescale 1ns/1ns
module tb;
    localparam [39:0] VOLS = 40'h06_07_cf_fe_ff; // Left codes to try
    localparam [31:0] RJW  = 32'h10_12_14_18;    // Lengths, codes 3..0
    reg        ref_clk = 1'b0;      // 10 MHz reference clock
    reg        rst_n   = 1'b0;      // Reset, active low
    wire       scl, mst_low, sda;   // Link clock, master pull, data
    wire       sda_out, sda_oe;     // Device data drive
    wire       skip, speed, fade;   // Path control flags
    wire       f_rj, f_i2s, f_lj;   // Framing flags
    wire       side, amute;         // Input pick, 50/50 mute
    wire [1:0] boost;               // Boost code
    wire [4:0] rj_bits;             // Right-justified length
    wire [7:0] lcode, rcode;        // Applied gain codes
    wire [8:0] lhalf, rhalf, ahalf; // Gains in half dB
    integer    miscompares = 0;     // Mismatches
    integer    num_checks  = 0;     // Comparisons
    integer    cycles      = 0;     // Timeout count
    integer    i;                   // Loop index
    reg  [7:0] d, rd;               // Byte written, byte read
    reg        ok;                  // Acknowledge seen

    // Open-drain data wire with pull-up
    assign sda = (mst_low || (sda_oe && !sda_out)) ? 1'b0 : 1'b1;
    // Reference clock
    always #50 ref_clk = ~ref_clk;

    apc_audio_path_regs #(.DEV_ADDR(7'h2a)) apc_audio_path_regs_i (
        .ref_clk(ref_clk), .rst_n(rst_n), .scl_pin(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .lowcut_filter_skip(skip),
        .boost_shift(boost), .rate_speed_select(speed),
        .fmt_right_just(f_rj), .fmt_i2s(f_i2s), .fmt_left_just(f_lj),
        .rj_word_bits(rj_bits), .fade_enable(fade),
        .input_side_select(side), .left_gain_code(lcode),
        .right_gain_code(rcode), .left_gain_half_db(lhalf),
        .right_gain_half_db(rhalf), .amp_gain_half_db(ahalf),
        .amp_mute_5050(amute)
    );
    apc_ctl_master apc_ctl_master_i (
        .ref_clk(ref_clk), .sda(sda), .scl(scl), .sda_low(mst_low)
    );

    // Count a comparison, report a mismatch
    task chk(input [8:0] got, input [8:0] exp);
        num_checks = num_checks + 1;
        if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Write a register, then let the outputs settle
    task wr(input [7:0] ptr, input [7:0] v);
        apc_ctl_master_i.reg_write(7'h2a, ptr, v, ok);
        chk(9'(ok), 9'h001);
        repeat (6) @(posedge ref_clk);
    endtask
    // Read a register, compare value and acknowledges
    task rdc(input [7:0] ptr, input [7:0] exp);
        apc_ctl_master_i.reg_read(7'h2a, ptr, rd, ok);
        chk({ok, rd}, {1'b1, exp});
    endtask
    // Counts and verdict
    task end_sim;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Cut a hang short
    always @(posedge ref_clk) begin
        cycles = cycles + 1;
        if (cycles == 40000) begin
            miscompares = miscompares + 1;
            end_sim;
        end
    end

    // Main sequence
    initial begin
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge ref_clk);
        chk({7'h00, skip, speed}, 9'h000);
        chk({7'h00, boost}, 9'h001);
        chk({6'h00, f_i2s, f_rj, f_lj}, 9'h004);
        chk({7'h00, fade, side}, 9'h002);
        rdc(8'h02, 8'h14);
        rdc(8'h03, 8'h80);
        rdc(8'h04, 8'hcf);
        rdc(8'h05, 8'hcf);
        rdc(8'h06, 8'h51);
        rdc(8'h07, 8'h00);
        // Long fade down to the floor code
        wr(8'h04, 8'h07);
        chk(9'(lcode > 8'h07 && lcode < 8'hcf), 9'h001);
        rdc(8'h04, 8'h07);
        repeat (4100) @(posedge ref_clk);
        chk({1'b0, lcode}, 9'h007);
        chk(lhalf, 9'h138);
        chk(ahalf, 9'h000);
        // Fade off, left input picked: codes jump
        wr(8'h03, 8'h00);
        chk(9'(fade), 9'h000);
        wr(8'h06, 8'h53);
        for (i = 0; i < 5; i = i + 1) begin
            d = VOLS[8*i +: 8];
            wr(8'h04, d);
            chk({1'b0, lcode}, {1'b0, d});
            chk(ahalf, {1'b0, d} - 9'h0cf);
            chk(9'(amute), 9'(d < 8'h07));
        end
        // Mute bits force the applied codes to zero
        wr(8'h04, 8'hcf);
        wr(8'h03, 8'h01);
        chk({amute, lcode}, 9'h100);
        rdc(8'h03, 8'h01);
        wr(8'h03, 8'h02);
        chk({amute, lcode}, 9'h0cf);
        chk({1'b0, rcode}, 9'h000);
        wr(8'h06, 8'h51);
        chk({amute, 8'h00}, 9'h100);
        chk(ahalf, 9'h131);
        chk(rhalf, 9'h131);
        wr(8'h03, 8'h00);
        wr(8'h05, 8'h06);
        chk({amute, rcode}, 9'h106);
        // Every legal format code, with skip, boost and speed varied
        for (i = 0; i < 6; i = i + 1) begin
            d = {i[0], 1'b0, i[1:0], i[0], i[2:0]};
            wr(8'h02, d);
            rdc(8'h02, d);
            chk(9'({skip, boost}), 9'({d[7], d[5:4]}));
            chk(9'(speed), 9'(d[3]));
            chk(9'({f_rj, f_i2s, f_lj}),
                9'({i < 4, i == 4, i == 5}));
            chk({4'h0, rj_bits},
                (i < 4) ? {1'b0, RJW[8*i +: 8]} : 9'h000);
        end
        // Wrong device address is not acknowledged and writes nothing
        apc_ctl_master_i.reg_write(7'h2b, 8'h02, 8'h00, ok);
        chk(9'(ok), 9'h000);
        rdc(8'h02, 8'h9d);
        end_sim;
    end
endmodule // tb
